// >>> pcin_pkg.sv
`timescale 1ns/1ps
package pcin_pkg;
  // Clock and time figures
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RST_MIN_SHORT_MS = 100;
  localparam int unsigned RST_MIN_LONG_MS  = 350;
  localparam int unsigned RST_MAX_S        = 30;
  localparam int unsigned CYC_TIME_MAX_S   = 500;
  localparam int unsigned RST_MIN_SHORT_CYC = RST_MIN_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_MIN_LONG_CYC  = RST_MIN_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_MAX_CYC       = RST_MAX_S * CLK_HZ;
  localparam int unsigned TICKS_PER_SEC     = CLK_HZ;
  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // Control field positions
  localparam int unsigned CTRL_ILK_LSB   = 0;
  localparam int unsigned CTRL_LONG_BIT  = 2;
  localparam int unsigned CTRL_TDC_BIT   = 3;
  localparam int unsigned CTRL_NCYC_LSB  = 4;
  localparam int unsigned CTRL_TIME_LSB  = 8;
  // Control encodings, reset values and limits
  localparam logic [1:0] ILK_NONE   = 2'h0;
  localparam logic [1:0] ILK_ALWAYS = 2'h1;
  localparam logic [1:0] ILK_AFTER  = 2'h2;
  localparam logic [1:0] RST_ILK    = ILK_ALWAYS;
  localparam logic [3:0] RST_NCYC   = 4'h1;
  localparam logic [3:0] NCYC_MAX   = 4'h8;
  localparam logic [8:0] RST_TIME   = 9'h000;
  localparam logic [8:0] TIME_MAX   = 9'h1F4;
  typedef enum logic [2:0] {
    ST_LOCKED,
    ST_WAIT_CYC,
    ST_WAIT_RST,
    ST_RUN
  } pcin_state_t;
endpackage : pcin_pkg

module pcin_pulse_meter #(
  parameter int unsigned MIN_SHORT = pcin_pkg::RST_MIN_SHORT_CYC,
  parameter int unsigned MIN_LONG  = pcin_pkg::RST_MIN_LONG_CYC,
  parameter int unsigned MAX_LEN   = pcin_pkg::RST_MAX_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pulse input and option
  input  wire logic sig,
  input  wire logic sel_long,
  // Result
  output logic      valid
);
  localparam int unsigned W = $clog2(MAX_LEN + 2);
  localparam logic [W-1:0] MIN_S = W'(MIN_SHORT);
  localparam logic [W-1:0] MIN_L = W'(MIN_LONG);
  localparam logic [W-1:0] MAX_L = W'(MAX_LEN);

  logic [W-1:0] len_ff;
  logic         sig_d_ff;
  logic         valid_ff;
  logic [W-1:0] min_len;

  assign min_len = sel_long ? MIN_L : MIN_S;
  assign valid   = valid_ff;

  // Width of the high phase, saturating above the longest allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_ff <= '0;
    end else if (!sig) begin
      len_ff <= '0;
    end else if (len_ff <= MAX_L) begin
      len_ff <= len_ff + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_d_ff <= 1'b0;
    end else begin
      sig_d_ff <= sig;
    end
  end

  // Accept at the falling edge only inside the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= sig_d_ff && !sig && (len_ff >= min_len) && (len_ff <= MAX_L); // see RL17
    end
  end
endmodule : pcin_pulse_meter

// >>> pcin_press_cycle.sv
`timescale 1ns/1ps
// Operation
// RL1 - Restart interlock selectable: none, always, or after downstroke or initial stop.
// RL2 - Minimum restart pulse selectable as 100 ms or 350 ms.
// RL3 - A build switch decides whether the error flag output exists; the code always keeps the port and ties it low when USE_ERROR_FLAG is off.
// RL4 - Press enable output permits the press process while high.
// RL5 - Restart needed output high while a tripped interlock awaits restart.
// RL6 - Cycle needed output high while further interventions are required.
// RL7 - Timeout output rises when the cycle time interval is exceeded.
// RL8 - Violation output rises on any intervention not allowed now.
// RL9 - Stop away from top dead center flags and blocks start until back.
// RL10 - Error flag rises on timeout or unexpected intervention when present.
// RL11 - Each high-low-high sequence on the cycle input counts one intervention.
// RL12 - Block validates the start sequence and clears counter or state.
// RL13 - Main enable and cycle input high raise cycle needed.
// RL14 - A following complete intervention raises press enable.
// RL15 - Integrator keeps at most two interventions and 30 s cycle time; the code allows up to 8 interventions and 500 s.
// RL16 - Cycle time monitoring is off at zero or 1 to 500 s.
// RL17 - Restart pulses too short or above 30 s are ignored.
// RL18 - Too many interventions drop press enable and raise violation at once.
// RL19 - Enable is granted only after exactly the configured intervention count.
// RL20 - Time limits count clock cycles; inputs are sampled synchronously.
module pcin_press_cycle #(
  parameter bit          USE_ERROR_FLAG = 1'b1,
  parameter int unsigned TICKS_PER_SEC  = pcin_pkg::TICKS_PER_SEC,
  parameter int unsigned RST_MIN_SHORT  = pcin_pkg::RST_MIN_SHORT_CYC,
  parameter int unsigned RST_MIN_LONG   = pcin_pkg::RST_MIN_LONG_CYC,
  parameter int unsigned RST_MAX        = pcin_pkg::RST_MAX_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Press and sensor pins
  input  wire logic        main_release,
  input  wire logic        cycle_in,
  input  wire logic        top_dead_center,
  input  wire logic        restart_in,
  // Press status
  output logic             press_enable,
  output logic             restart_needed,
  output logic             cycle_needed,
  output logic             cycle_time_exceeded,
  output logic             field_violation,
  output logic             start_refused,
  output logic             error_flag
);
  localparam int unsigned PW = $clog2(TICKS_PER_SEC + 1);

  pcin_pkg::pcin_state_t state_ff;
  logic [3:0]  sync1_ff;
  logic [3:0]  sync2_ff;
  logic [3:0]  prev_ff;
  logic        rel_s;
  logic        cyc_s;
  logic        top_s;
  logic        rst_s;
  logic        cyc_fall;
  logic        top_rise;
  logic        low_seen_ff;
  logic        int_evt;
  logic        rst_valid;
  logic [1:0]  ilk_ff;
  logic        long_ff;
  logic        tdc_only_ff;
  logic [3:0]  ncyc_ff;
  logic [8:0]  ctime_ff;
  logic [3:0]  count_ff;
  logic [PW-1:0] presc_ff;
  logic [8:0]  secs_ff;
  logic        timeout_ff;
  logic        viol_ff;
  logic        refuse_ff;
  logic        pend_ff;
  logic        stop;
  logic        viol_evt;
  logic        tmo_evt;
  logic        may_start;
  logic [31:0] prdata_ff;
  logic        wr_en;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pcin_pkg::OFS_CTRL) || (a == pcin_pkg::OFS_STATUS);
  endfunction : mapped

  // Pin synchronisers, edges taken from the second stage onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff  <= 4'h0;
    end else begin
      sync1_ff <= {restart_in, top_dead_center, cycle_in, main_release}; // see RL20
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign rel_s    = sync2_ff[0];
  assign cyc_s    = sync2_ff[1];
  assign top_s    = sync2_ff[2];
  assign rst_s    = sync2_ff[3];
  assign cyc_fall = prev_ff[1] && !cyc_s;
  assign top_rise = !prev_ff[2] && top_s;

  // Intervention: a fall, then the next rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_seen_ff <= 1'b0;
    end else if (cyc_fall) begin
      low_seen_ff <= 1'b1;
    end else if (cyc_s) begin
      low_seen_ff <= 1'b0;
    end
  end

  assign int_evt = low_seen_ff && cyc_s; // see RL11

  pcin_pulse_meter #(
    .MIN_SHORT (RST_MIN_SHORT),
    .MIN_LONG  (RST_MIN_LONG),
    .MAX_LEN   (RST_MAX)
  ) u_restart (
    .pclk     (pclk),
    .presetn  (presetn),
    .sig      (rst_s),
    .sel_long (long_ff), // see RL2
    .valid    (rst_valid)
  );

  // APB: zero wait, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_ff;
  assign wr_en   = psel && penable && pwrite && (paddr == pcin_pkg::OFS_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      if (paddr == pcin_pkg::OFS_CTRL) begin
        prdata_ff[pcin_pkg::CTRL_ILK_LSB +: 2]  <= ilk_ff;
        prdata_ff[pcin_pkg::CTRL_LONG_BIT]      <= long_ff;
        prdata_ff[pcin_pkg::CTRL_TDC_BIT]       <= tdc_only_ff;
        prdata_ff[pcin_pkg::CTRL_NCYC_LSB +: 4] <= ncyc_ff;
        prdata_ff[pcin_pkg::CTRL_TIME_LSB +: 9] <= ctime_ff;
      end else if (paddr == pcin_pkg::OFS_STATUS) begin
        prdata_ff[12:0] <= {secs_ff, count_ff};
        prdata_ff[21:16] <= {start_refused, field_violation, cycle_time_exceeded,
                             cycle_needed, restart_needed, press_enable};
      end
    end
  end

  // Configuration register; out of range counts and times are clamped, interlock code 3 becomes always
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilk_ff      <= pcin_pkg::RST_ILK;
      long_ff     <= 1'b0;
      tdc_only_ff <= 1'b0;
      ncyc_ff     <= pcin_pkg::RST_NCYC;
      ctime_ff    <= pcin_pkg::RST_TIME;
    end else if (wr_en) begin
      ilk_ff      <= (pwdata[pcin_pkg::CTRL_ILK_LSB +: 2] == 2'h3) ? pcin_pkg::ILK_ALWAYS
                     : pwdata[pcin_pkg::CTRL_ILK_LSB +: 2]; // see RL1
      long_ff     <= pwdata[pcin_pkg::CTRL_LONG_BIT];
      tdc_only_ff <= pwdata[pcin_pkg::CTRL_TDC_BIT];
      ncyc_ff     <= (pwdata[pcin_pkg::CTRL_NCYC_LSB +: 4] == 4'h0) ? pcin_pkg::RST_NCYC
                     : (pwdata[pcin_pkg::CTRL_NCYC_LSB +: 4] > pcin_pkg::NCYC_MAX)
                     ? pcin_pkg::NCYC_MAX : pwdata[pcin_pkg::CTRL_NCYC_LSB +: 4];
      ctime_ff    <= (pwdata[pcin_pkg::CTRL_TIME_LSB +: 9] > pcin_pkg::TIME_MAX)
                     ? pcin_pkg::TIME_MAX : pwdata[pcin_pkg::CTRL_TIME_LSB +: 9]; // see RL16
    end
  end

  // Events that stop the press
  assign viol_evt = ((state_ff == pcin_pkg::ST_RUN) && cyc_fall)
                 || ((state_ff == pcin_pkg::ST_WAIT_RST) && int_evt); // see RL8
  assign tmo_evt  = (ctime_ff != 9'h000) && (secs_ff >= ctime_ff)
                 && ((state_ff == pcin_pkg::ST_WAIT_CYC) || (state_ff == pcin_pkg::ST_WAIT_RST));
  assign stop     = (state_ff != pcin_pkg::ST_LOCKED) && (!rel_s || viol_evt || tmo_evt);
  assign may_start = rel_s && cyc_s && !refuse_ff && (!tdc_only_ff || top_s);

  // Sequence control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pcin_pkg::ST_LOCKED;
    end else if (stop) begin
      state_ff <= pcin_pkg::ST_LOCKED; // see RL18
    end else begin
      case (state_ff)
        pcin_pkg::ST_LOCKED: begin
          if (may_start) begin
            state_ff <= pcin_pkg::ST_WAIT_CYC; // see RL13
          end
        end
        pcin_pkg::ST_WAIT_CYC: begin
          if (int_evt && (count_ff + 4'h1 == ncyc_ff)) begin
            state_ff <= pend_ff ? pcin_pkg::ST_WAIT_RST : pcin_pkg::ST_RUN; // see RL14
          end
        end
        pcin_pkg::ST_WAIT_RST: begin
          if (rst_valid) begin
            state_ff <= pcin_pkg::ST_RUN; // see RL5
          end
        end
        pcin_pkg::ST_RUN: begin
          if (top_rise) begin
            state_ff <= pcin_pkg::ST_WAIT_CYC; // see RL12
          end
        end
        default: state_ff <= pcin_pkg::ST_LOCKED;
      endcase
    end
  end

  // Intervention counter, cleared at each new sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 4'h0;
    end else if (state_ff != pcin_pkg::ST_WAIT_CYC) begin
      count_ff <= 4'h0; // see RL12
    end else if (int_evt) begin
      count_ff <= count_ff + 4'h1; // see RL19
    end
  end

  // Cycle time in seconds, restarted with each new sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= '0;
      secs_ff  <= 9'h000;
    end else if ((state_ff == pcin_pkg::ST_LOCKED) || (state_ff == pcin_pkg::ST_RUN)) begin
      presc_ff <= '0;
      secs_ff  <= 9'h000;
    end else if (presc_ff == PW'(TICKS_PER_SEC - 1)) begin
      presc_ff <= '0;
      if (secs_ff != pcin_pkg::TIME_MAX) begin
        secs_ff <= secs_ff + 9'h001; // see RL20
      end
    end else begin
      presc_ff <= presc_ff + PW'(1);
    end
  end

  // Sticky fault flags, cleared only by a completed start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_ff <= 1'b0;
      viol_ff    <= 1'b0;
    end else begin
      if (tmo_evt) begin
        timeout_ff <= 1'b1; // see RL7
      end else if (state_ff == pcin_pkg::ST_RUN) begin
        timeout_ff <= 1'b0;
      end
      if (viol_evt) begin
        viol_ff <= 1'b1; // see RL8
      end else if (state_ff == pcin_pkg::ST_RUN) begin
        viol_ff <= 1'b0;
      end
    end
  end

  // Stop away from top dead center blocks a new start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refuse_ff <= 1'b0;
    end else if (stop && !top_s) begin
      refuse_ff <= 1'b1; // see RL9
    end else if (top_s) begin
      refuse_ff <= 1'b0;
    end
  end

  // Restart interlock pending; set at power up unless disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b1;
    end else if (ilk_ff == pcin_pkg::ILK_NONE) begin
      pend_ff <= 1'b0; // see RL1
    end else if (stop && ((ilk_ff == pcin_pkg::ILK_ALWAYS) || (state_ff == pcin_pkg::ST_RUN))) begin
      pend_ff <= 1'b1;
    end else if (state_ff == pcin_pkg::ST_RUN) begin
      pend_ff <= 1'b0;
    end
  end

  assign press_enable        = (state_ff == pcin_pkg::ST_RUN); // see RL4
  assign restart_needed      = (state_ff == pcin_pkg::ST_WAIT_RST); // see RL5
  assign cycle_needed        = (state_ff == pcin_pkg::ST_WAIT_CYC); // see RL6
  assign cycle_time_exceeded = timeout_ff;
  assign field_violation     = viol_ff;
  assign start_refused       = refuse_ff;

  generate
    if (USE_ERROR_FLAG) begin : g_err
      assign error_flag = timeout_ff || viol_ff; // see RL10
    end else begin : g_no_err
      assign error_flag = 1'b0; // see RL3
    end
  endgenerate

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_enable_exact_count: assert property ( // see RL19
    $rose(press_enable) && $past(state_ff) == pcin_pkg::ST_WAIT_CYC
      |-> $past(count_ff) + 4'h1 == ncyc_ff)
    else $error("enable granted with wrong intervention count");
  chk_extra_intervention: assert property ( // see RL18
    (state_ff == pcin_pkg::ST_WAIT_RST) && int_evt && rel_s |=> !press_enable && field_violation)
    else $error("extra intervention not treated as violation");
  chk_run_violation: assert property ( // see RL8
    press_enable && cyc_fall |=> !press_enable ##0 field_violation)
    else $error("intervention during run did not stop press");
  chk_cycle_needed_on: assert property ( // see RL13
    (state_ff == pcin_pkg::ST_LOCKED) && may_start |=> cycle_needed)
    else $error("cycle needed not raised after release and cycle high");
  chk_count_step: assert property ( // see RL11
    cycle_needed && int_evt && !stop && (count_ff + 4'h1 != ncyc_ff)
      |=> count_ff == $past(count_ff) + 4'h1)
    else $error("intervention not counted");
  chk_timeout_stops: assert property ( // see RL7
    $rose(cycle_time_exceeded) |-> !press_enable && !cycle_needed)
    else $error("timeout did not stop the sequence");
  chk_error_follows: assert property ( // see RL10
    $rose(field_violation) || $rose(cycle_time_exceeded) |-> error_flag == USE_ERROR_FLAG)
    else $error("error flag does not follow fault");
  chk_refuse_blocks: assert property ( // see RL9
    start_refused && (state_ff == pcin_pkg::ST_LOCKED) |=> !cycle_needed)
    else $error("start taken away from top dead center");
  chk_restart_excl: assert property ( // see RL5
    restart_needed |-> !press_enable ##1 (!press_enable || $past(rst_valid)))
    else $error("enable without valid restart");
  chk_release_drop: assert property ( // see RL12
    !rel_s && (state_ff != pcin_pkg::ST_LOCKED) |=> !press_enable && !cycle_needed)
    else $error("main release low did not lock");

  cov_enable: cover property ($rose(press_enable));
  cov_restart: cover property (restart_needed ##1 press_enable);
  cov_violation: cover property ($rose(field_violation));
  cov_timeout: cover property ($rose(cycle_time_exceeded));
endmodule : pcin_press_cycle

// >>> pcin_partner.sv
`timescale 1ns/1ps
module pcin_partner (
  // Clock
  input  wire logic pclk,
  // Press and curtain pins
  output logic      main_release,
  output logic      cycle_in,
  output logic      top_dead_center,
  output logic      restart_in
);
  initial begin
    main_release    = 1'b0;
    cycle_in        = 1'b1;
    top_dead_center = 1'b1;
    restart_in      = 1'b0;
  end
  // Main release and stroke position levels
  task set_pins(input logic rel, input logic top);
    @(posedge pclk);
    main_release    <= rel;
    top_dead_center <= top;
  endtask : set_pins
  // Operator reaches in and leaves the curtain again
  task intervene;
    @(posedge pclk);
    cycle_in <= 1'b0;
    repeat (3) @(posedge pclk);
    cycle_in <= 1'b1;
  endtask : intervene
  // Restart button held for n clocks
  task restart_pulse(input int n);
    @(posedge pclk);
    restart_in <= 1'b1;
    repeat (n) @(posedge pclk);
    restart_in <= 1'b0;
  endtask : restart_pulse
endmodule : pcin_partner

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        main_release;
  logic        cycle_in;
  logic        top_dead_center;
  logic        restart_in;
  logic        press_enable;
  logic        restart_needed;
  logic        cycle_needed;
  logic        cycle_time_exceeded;
  logic        field_violation;
  logic        start_refused;
  logic        error_flag;
  int          bad_count;
  int          comparisons;
  int          cycles;
  logic [31:0] rdat;
  logic        rerr;

  pcin_press_cycle #(
    .TICKS_PER_SEC (20),
    .RST_MIN_SHORT (4),
    .RST_MIN_LONG  (8),
    .RST_MAX       (40)
  ) pcin_press_cycle_inst (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .main_release       (main_release),
    .cycle_in           (cycle_in),
    .top_dead_center    (top_dead_center),
    .restart_in         (restart_in),
    .press_enable       (press_enable),
    .restart_needed     (restart_needed),
    .cycle_needed       (cycle_needed),
    .cycle_time_exceeded(cycle_time_exceeded),
    .field_violation    (field_violation),
    .start_refused      (start_refused),
    .error_flag         (error_flag)
  );

  pcin_partner pcin_partner_inst (
    .pclk           (pclk),
    .main_release   (main_release),
    .cycle_in       (cycle_in),
    .top_dead_center(top_dead_center),
    .restart_in     (restart_in)
  );

  always #25 pclk = ~pclk;

  task report_and_stop;
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, rerr);
    check(rdat, exp);
  endtask : rd

  function automatic logic [31:0] ctl(input logic [1:0] i, input logic l,
                                      input logic [3:0] n, input logic [8:0] t);
    return {15'h0000, t, n, 1'b0, l, i};
  endfunction : ctl

  task settle;
    repeat (8) @(posedge pclk);
    #1;
  endtask : settle

  // New settings, then a release cycle to start from a clean stop
  task relock(input logic [31:0] c);
    apb(1'b1, pcin_pkg::OFS_CTRL, c, rdat, rerr);
    pcin_partner_inst.set_pins(1'b0, 1'b1);
    settle();
    pcin_partner_inst.set_pins(1'b1, 1'b1);
    settle();
  endtask : relock

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(pcin_pkg::OFS_CTRL, 32'h00000011);
    apb(1'b1, pcin_pkg::OFS_STATUS, 32'hFFFFFFFF, rdat, rerr);
    rd(pcin_pkg::OFS_STATUS, 32'h0);
    rd(8'h08, 32'h0);
    check({31'h0, rerr}, 32'h1);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, pcin_pkg::OFS_CTRL, ctl(v[1:0], 1'b0, 4'h1, 9'h000), rdat, rerr);
      rd(pcin_pkg::OFS_CTRL, ctl((v == 3) ? 2'h1 : v[1:0], 1'b0, 4'h1, 9'h000));
    end
    apb(1'b1, pcin_pkg::OFS_CTRL, ctl(2'h0, 1'b1, 4'hF, 9'h1FF), rdat, rerr);
    rd(pcin_pkg::OFS_CTRL, ctl(2'h0, 1'b1, pcin_pkg::NCYC_MAX, pcin_pkg::TIME_MAX));
    // Minimum configuration
    relock(ctl(pcin_pkg::ILK_NONE, 1'b0, 4'h1, 9'h000));
    check(cycle_needed, 32'h1);
    check(press_enable, 32'h0);
    pcin_partner_inst.intervene();
    settle();
    check(press_enable, 32'h1);
    check(cycle_needed, 32'h0);
    apb(1'b0, pcin_pkg::OFS_STATUS, 32'h0, rdat, rerr);
    check({26'h0, rdat[21:16]}, 32'h1);
    pcin_partner_inst.intervene();
    settle();
    check(press_enable, 32'h0);
    check(field_violation, 32'h1);
    check(error_flag, 32'h1);
    // Two interventions required
    relock(ctl(pcin_pkg::ILK_NONE, 1'b0, 4'h2, 9'h000));
    pcin_partner_inst.intervene();
    settle();
    check(press_enable, 32'h0);
    check(cycle_needed, 32'h1);
    pcin_partner_inst.intervene();
    settle();
    check(press_enable, 32'h1);
    check(field_violation, 32'h0);
    pcin_partner_inst.intervene();
    settle();
    check(press_enable, 32'h0);
    check(field_violation, 32'h1);
    // Restart interlock with both minimum pulse settings
    for (int l = 0; l < 2; l++) begin
      relock(ctl(pcin_pkg::ILK_ALWAYS, l[0], 4'h1, 9'h000));
      pcin_partner_inst.intervene();
      settle();
      check(restart_needed, 32'h1);
      check(press_enable, 32'h0);
      pcin_partner_inst.restart_pulse((l == 1) ? 6 : 2);
      settle();
      check(restart_needed, 32'h1);
      pcin_partner_inst.restart_pulse(50);
      settle();
      check(restart_needed, 32'h1);
      pcin_partner_inst.restart_pulse((l == 1) ? 10 : 6);
      settle();
      check(press_enable, 32'h1);
      check(restart_needed, 32'h0);
    end
    // Stop in the downstroke
    pcin_partner_inst.set_pins(1'b1, 1'b0);
    settle();
    pcin_partner_inst.set_pins(1'b0, 1'b0);
    settle();
    check(start_refused, 32'h1);
    check(press_enable, 32'h0);
    pcin_partner_inst.set_pins(1'b1, 1'b0);
    settle();
    check(cycle_needed, 32'h0);
    pcin_partner_inst.set_pins(1'b1, 1'b1);
    settle();
    check(start_refused, 32'h0);
    check(cycle_needed, 32'h1);
    // Extra intervention while a restart is awaited
    pcin_partner_inst.intervene();
    settle();
    check(restart_needed, 32'h1);
    pcin_partner_inst.intervene();
    settle();
    check(restart_needed, 32'h0);
    check(field_violation, 32'h1);
    // Start only at top dead center
    apb(1'b1, pcin_pkg::OFS_CTRL, ctl(pcin_pkg::ILK_NONE, 1'b0, 4'h1, 9'h000) | 32'h8, rdat, rerr);
    pcin_partner_inst.set_pins(1'b0, 1'b1);
    settle();
    pcin_partner_inst.set_pins(1'b0, 1'b0);
    settle();
    pcin_partner_inst.set_pins(1'b1, 1'b0);
    settle();
    check(cycle_needed, 32'h0);
    check(start_refused, 32'h0);
    pcin_partner_inst.set_pins(1'b1, 1'b1);
    settle();
    check(cycle_needed, 32'h1);
    // Cycle time of one second
    relock(ctl(pcin_pkg::ILK_NONE, 1'b0, 4'h1, 9'h001));
    check(cycle_time_exceeded, 32'h0);
    repeat (40) @(posedge pclk);
    #1;
    check(cycle_time_exceeded, 32'h1);
    check(error_flag, 32'h1);
    // Interlock only after a stop while running
    apb(1'b1, pcin_pkg::OFS_CTRL, ctl(pcin_pkg::ILK_AFTER, 1'b0, 4'h1, 9'h000), rdat, rerr);
    pcin_partner_inst.intervene();
    settle();
    check(press_enable, 32'h1);
    pcin_partner_inst.set_pins(1'b0, 1'b1);
    settle();
    pcin_partner_inst.set_pins(1'b1, 1'b1);
    settle();
    pcin_partner_inst.intervene();
    settle();
    check(restart_needed, 32'h1);
    check(cycle_time_exceeded, 32'h0);
    report_and_stop();
  end
endmodule : testbench
